// ---- verilog/rsm_pkg.sv ----
// Package of shared constants for the reset sequence manager.
// Assumes a 100 MHz system clock and AHB-Lite word registers.
package rsm_pkg;
   // Register indices; byte address is four times the index
   localparam logic [7:0] KEY_LOW_IDX = 8'h47;
   localparam logic [7:0] KEY_HIGH_IDX = 8'h48;
   localparam logic [7:0] CAUSE_IDX = 8'h49;
   localparam logic [7:0] KEY_RESET = 8'h00;
   localparam logic [7:0] KEY_LOW_PORT = 8'h55;
   localparam logic [7:0] KEY_HIGH_PORT = 8'hAA;
   // Cause register field positions
   localparam int CAUSE_EXT_BIT = 0;
   localparam int CAUSE_POR_BIT = 1;
   localparam int CAUSE_DROP_BIT = 2;
   localparam int CAUSE_WDG_BIT = 3;
   localparam int CAUSE_ILL_BIT = 4;
   // Timing
   localparam int CLK_PERIOD_NS = 10;
   localparam int DELAY_CYCLES = 64;
   localparam int FETCH_CYCLES = 2;
   // Pin echo guard; must outlast pin sync plus latch sync after our own release
   localparam int PIN_SETTLE_CYCLES = 10;
   localparam int WDG_OUT_WIDTH_NS = 500;
   localparam int WDG_OUT_CYCLES = (WDG_OUT_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [15:0] RESET_VECTOR_ADDR = 16'hFFFE;
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   typedef enum logic [1:0] {
      ST_RUN = 2'b00,
      ST_ACTIVE = 2'b01,
      ST_DELAY = 2'b10,
      ST_FETCH = 2'b11
   } seq_state_t;
endpackage

// ---- verilog/rst_catch_if.sv ----
// Interface between the sequencer and the external reset catcher.
// Assumes both ends run on sys_clk.
`timescale 1ns/1ps
`default_nettype none
interface rst_catch_if;
   logic seen;     // Latched external low pulse, synchronised
   logic pinHigh;  // Filtered pin level
   logic clear;    // Release the latch
   modport catcher (output seen, output pinHigh, input clear);
   modport user (input seen, input pinHigh, output clear);
endinterface
`default_nettype wire

// ---- verilog/ext_reset_catcher.sv ----
// Clockless catcher of a low pulse on the shared reset pin.
// Assumes pinIn is the raw pin level from outside any clock domain.
`timescale 1ns/1ps
`default_nettype none
module ext_reset_catcher
   import rsm_pkg::*;
(
   input wire logic sys_clk,      // System clock
   input wire logic reset,        // Synchronous reset, high
   input wire logic pinIn,        // Raw pin level
   rst_catch_if.catcher cif       // Sequencer side
);
   logic caught_ff, nxt_caught;
   logic [2:0] catchSync_ff, nxt_catchSync;
   logic [2:0] pinSync_ff, nxt_pinSync;
   logic pinHigh_ff, nxt_pinHigh;

   ////////////////////////////////////////////////////////////////////////
   // Latch release only once the pin is seen high again
   always_comb begin
      nxt_caught = caught_ff;
      if (reset || (cif.clear && pinHigh_ff)) begin
         nxt_caught = 1'b0;
      end
   end

   // Pin falling edge sets without any clock, so halt cannot hide it
   always_ff @(posedge sys_clk or negedge pinIn) begin
      if (!pinIn) begin
         caught_ff <= 1'b1; // R8
      end else begin
         caught_ff <= nxt_caught;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Three-stage synchronisers; the pin level changes once stages two and three agree, seen needs both stages high
   always_comb begin
      nxt_catchSync = {catchSync_ff[1:0], caught_ff};
      nxt_pinSync = {pinSync_ff[1:0], pinIn};
      nxt_pinHigh = pinHigh_ff;
      if (pinSync_ff[1] == pinSync_ff[2]) begin
         nxt_pinHigh = pinSync_ff[2];
      end
      if (reset) begin
         nxt_catchSync = 3'h0;
         nxt_pinSync = 3'h7;
         nxt_pinHigh = 1'b1;
      end
   end

   always_ff @(posedge sys_clk) begin
      catchSync_ff <= nxt_catchSync;
      pinSync_ff <= nxt_pinSync;
      pinHigh_ff <= nxt_pinHigh;
   end

   assign cif.seen = catchSync_ff[1] & catchSync_ff[2];
   assign cif.pinHigh = pinHigh_ff;
endmodule
`default_nettype wire

// ---- verilog/reset_sequence_manager.sv ----
// Reset sequence manager: merges reset causes, runs the sequence,
// drives the shared reset pin and holds the write-once pin-function keys.
// Assumes an AHB-Lite master with single word transfers, and that the
// watchdog and illegal-opcode inputs are one-cycle pulses on sys_clk.
//
// Design decision made here: register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// [R1] A reset starts from an external pin pulse, the low supply detector or the watchdog.
// [R2] An illegal opcode or prebyte flagged by the decoder also starts a full reset.
// [R3] Every source drives the shared pin low, and it stays low through the whole delay.
// [R4] The sequence runs an active phase, then 64 clock cycles of delay, then the fetch.
// [R5] The vector fetch takes exactly 2 cycles and ends the sequence.
// [R6] The fetch reads the reset routine start from FFFEh and FFFFh.
// [R7] The pin is an input and an open-drain output, so outside logic may pull it low.
// [R8] An external low pulse is caught without the clock, so a halted part still resets.
// [R9] Low supply resets are told apart as power-on or drop, and hold the pin low throughout.
// [R10] A watchdog underflow holds the pin low for at least the watchdog output width.
// [R11] The 16-bit key pair is readable and writable, but each accepts one write per reset.
// [R12] Both keys clear on reset, and while both are zero the pin acts as reset.
// [R13] Writing 55h to the low key and AAh to the high key turns the pin into a port output.
// [R14] Once in port mode, software cannot bring back the reset function.
// [R15] Any internal reset clears both keys and restores the reset function of the pin.
// [R16] A new source during delay or fetch restarts from the active phase and reloads the delay.
module reset_sequence_manager
   import rsm_pkg::*;
(
   input wire logic sys_clk,            // System clock, 100 MHz
   input wire logic reset,              // Synchronous reset, high
   input wire logic hsel,               // AHB slave select
   input wire logic [31:0] haddr,       // AHB address
   input wire logic [1:0] htrans,       // AHB transfer type
   input wire logic hwrite,             // AHB write
   input wire logic [2:0] hsize,        // AHB size, word only
   input wire logic [31:0] hwdata,      // AHB write data
   input wire logic hready,             // AHB bus ready
   output logic [31:0] hrdata,          // AHB read data
   output logic hreadyout,              // AHB slave ready
   output logic hresp,                  // AHB response, always OKAY
   input wire logic resetPinIn,         // Shared pin level
   output logic resetPinOut,            // Shared pin drive value
   output logic resetPinOe,             // Shared pin drive enable
   input wire logic portData,           // Port output value in port mode
   input wire logic lowSupply,          // Detector: supply below threshold
   input wire logic wdgUnderflow,       // Watchdog underflow pulse
   input wire logic illegalOpcode,      // Decoder illegal code pulse
   output logic coreResetHold,          // Core held in reset
   output logic vectorFetch,            // Vector fetch phase
   output logic [15:0] vectorAddr,      // Fetch address
   output logic portMode                // Pin works as port output
);
   rst_catch_if cif ();

   ext_reset_catcher catcher (
      .sys_clk(sys_clk),
      .reset(reset),
      .pinIn(resetPinIn),
      .cif(cif)
   );

   function automatic logic [7:0] word_index(input logic [31:0] addr);
      word_index = addr[9:2];
   endfunction

   seq_state_t state_ff, nxt_state;
   logic [5:0] delayCnt_ff, nxt_delayCnt;
   logic fetchCnt_ff, nxt_fetchCnt;
   logic [5:0] wdgCnt_ff, nxt_wdgCnt;
   logic [3:0] pinGuard_ff, nxt_pinGuard;
   logic [2:0] lvdSync_ff, nxt_lvdSync;
   logic lvdLow_ff, nxt_lvdLow;
   logic hasRun_ff, nxt_hasRun;
   logic [4:0] cause_ff, nxt_cause;
   logic [7:0] keyLow_ff, nxt_keyLow, keyHigh_ff, nxt_keyHigh;
   logic lowDone_ff, nxt_lowDone, highDone_ff, nxt_highDone;
   logic wrPend_ff, nxt_wrPend;
   logic [7:0] wrIdx_ff, nxt_wrIdx;
   logic [31:0] hrdata_ff, nxt_hrdata;
   logic pinOut_ff, nxt_pinOut, pinOe_ff, nxt_pinOe;
   logic holdOut_ff, fetchOut_ff, portOut_ff;
   logic [15:0] vecOut_ff;
   logic extReq, internalReq, anyReq, activeHold, portNow, accept;

   ////////////////////////////////////////////////////////////////////////
   // Source merging; the pin is ignored as input while we drive it or in port mode
   assign portNow = (keyLow_ff == KEY_LOW_PORT) && (keyHigh_ff == KEY_HIGH_PORT); // R13
   // Our own low drive also sets the catcher; the guard hides that echo until it drains
   assign extReq = cif.seen && !pinOe_ff && (pinGuard_ff == 4'h0) && !portNow; // R1 R7
   assign internalReq = lvdLow_ff || wdgUnderflow || illegalOpcode; // R1 R2
   assign anyReq = extReq || internalReq;
   assign activeHold = extReq || lvdLow_ff || (wdgCnt_ff != 6'h00); // R9 R10
   assign cif.clear = (state_ff != ST_RUN) || (pinGuard_ff != 4'h0);

   // Supply detector is asynchronous to the clock: three flops, agree on two
   always_comb begin
      nxt_lvdSync = {lvdSync_ff[1:0], lowSupply};
      nxt_lvdLow = lvdLow_ff;
      if (lvdSync_ff[1] == lvdSync_ff[2]) begin
         nxt_lvdLow = lvdSync_ff[2];
      end
      if (reset) begin
         nxt_lvdSync = 3'h0;
         nxt_lvdLow = 1'b0;
      end
   end

   always_ff @(posedge sys_clk) begin
      lvdSync_ff <= nxt_lvdSync;
      lvdLow_ff <= nxt_lvdLow;
   end

   ////////////////////////////////////////////////////////////////////////
   // Sequencer: run, active, delay, fetch
   always_comb begin
      nxt_state = state_ff;
      nxt_delayCnt = delayCnt_ff;
      nxt_fetchCnt = fetchCnt_ff;
      nxt_hasRun = hasRun_ff;
      nxt_cause = cause_ff;
      nxt_wdgCnt = (wdgCnt_ff != 6'h00) ? wdgCnt_ff - 6'h01 : 6'h00;
      if (wdgUnderflow) begin
         nxt_wdgCnt = 6'(WDG_OUT_CYCLES); // R10
      end
      // Reloaded while we drive; an outside pulse that ends while the guard still runs is lost
      nxt_pinGuard = (pinGuard_ff != 4'h0) ? pinGuard_ff - 4'h1 : 4'h0;
      if (pinOe_ff) begin
         nxt_pinGuard = 4'(PIN_SETTLE_CYCLES); // R7
      end
      if (anyReq && state_ff != ST_ACTIVE) begin
         nxt_cause = '0;
      end
      if (anyReq) begin
         nxt_cause[CAUSE_EXT_BIT] = nxt_cause[CAUSE_EXT_BIT] | extReq;
         nxt_cause[CAUSE_POR_BIT] = nxt_cause[CAUSE_POR_BIT] | (lvdLow_ff & !hasRun_ff); // R9
         nxt_cause[CAUSE_DROP_BIT] = nxt_cause[CAUSE_DROP_BIT] | (lvdLow_ff & hasRun_ff); // R9
         nxt_cause[CAUSE_WDG_BIT] = nxt_cause[CAUSE_WDG_BIT] | wdgUnderflow;
         nxt_cause[CAUSE_ILL_BIT] = nxt_cause[CAUSE_ILL_BIT] | illegalOpcode;
      end
      case (state_ff)
         ST_RUN: begin
            if (anyReq) begin
               nxt_state = ST_ACTIVE; // R1 R2
            end
         end
         ST_ACTIVE: begin
            if (!activeHold) begin
               nxt_state = ST_DELAY; // R4
            end
            nxt_delayCnt = 6'(DELAY_CYCLES - 1);
         end
         ST_DELAY: begin
            if (anyReq) begin
               nxt_state = ST_ACTIVE; // R16
            end else if (delayCnt_ff == 6'h00) begin
               nxt_state = ST_FETCH;
               nxt_fetchCnt = 1'b0;
            end else begin
               nxt_delayCnt = delayCnt_ff - 6'h01; // R4
            end
         end
         ST_FETCH: begin
            if (anyReq) begin
               nxt_state = ST_ACTIVE; // R16
            end else if (fetchCnt_ff) begin
               nxt_state = ST_RUN; // R5
               nxt_hasRun = 1'b1;
            end else begin
               nxt_fetchCnt = 1'b1;
            end
         end
         default: nxt_state = ST_ACTIVE;
      endcase
      if (reset) begin
         nxt_state = ST_ACTIVE;
         nxt_delayCnt = 6'(DELAY_CYCLES - 1);
         nxt_fetchCnt = 1'b0;
         nxt_wdgCnt = 6'h00;
         nxt_pinGuard = 4'(PIN_SETTLE_CYCLES);
         nxt_hasRun = 1'b0;
         nxt_cause = '0;
      end
   end

   always_ff @(posedge sys_clk) begin
      state_ff <= nxt_state;
      pinGuard_ff <= nxt_pinGuard;
      delayCnt_ff <= nxt_delayCnt;
      fetchCnt_ff <= nxt_fetchCnt;
      wdgCnt_ff <= nxt_wdgCnt;
      hasRun_ff <= nxt_hasRun;
      cause_ff <= nxt_cause;
   end

   ////////////////////////////////////////////////////////////////////////
   // Bus slave: zero wait states, address captured, data applied next cycle
   assign accept = hsel && hready && (htrans == HTRANS_NONSEQ);

   always_comb begin
      nxt_wrPend = accept && hwrite;
      nxt_wrIdx = word_index(haddr);
      nxt_hrdata = hrdata_ff;
      nxt_keyLow = keyLow_ff;
      nxt_keyHigh = keyHigh_ff;
      nxt_lowDone = lowDone_ff;
      nxt_highDone = highDone_ff;
      // Each key takes its first write only
      if (wrPend_ff && wrIdx_ff == KEY_LOW_IDX && !lowDone_ff) begin
         nxt_keyLow = hwdata[7:0]; // R11
         nxt_lowDone = 1'b1;
      end
      if (wrPend_ff && wrIdx_ff == KEY_HIGH_IDX && !highDone_ff) begin
         nxt_keyHigh = hwdata[7:0]; // R11
         nxt_highDone = 1'b1;
      end
      if (accept && !hwrite) begin
         case (word_index(haddr))
            KEY_LOW_IDX: nxt_hrdata = {24'h000000, nxt_keyLow};
            KEY_HIGH_IDX: nxt_hrdata = {24'h000000, nxt_keyHigh};
            CAUSE_IDX: nxt_hrdata = {27'h0000000, cause_ff};
            default: nxt_hrdata = 32'h00000000;
         endcase
      end
      // Any reset event clears both keys and reopens them
      if (reset || state_ff != ST_RUN || anyReq) begin
         nxt_keyLow = KEY_RESET; // R12 R15
         nxt_keyHigh = KEY_RESET; // R12 R15
         nxt_lowDone = 1'b0;
         nxt_highDone = 1'b0;
      end
      if (reset) begin
         nxt_wrPend = 1'b0;
         nxt_hrdata = 32'h00000000;
      end
   end

   always_ff @(posedge sys_clk) begin
      wrPend_ff <= nxt_wrPend;
      wrIdx_ff <= nxt_wrIdx;
      hrdata_ff <= nxt_hrdata;
      keyLow_ff <= nxt_keyLow;
      keyHigh_ff <= nxt_keyHigh;
      lowDone_ff <= nxt_lowDone;
      highDone_ff <= nxt_highDone;
   end

   ////////////////////////////////////////////////////////////////////////
   // Pin and core outputs, all registered
   always_comb begin
      nxt_pinOut = 1'b0;
      nxt_pinOe = 1'b0;
      if (nxt_state == ST_ACTIVE || nxt_state == ST_DELAY) begin
         nxt_pinOe = 1'b1; // R3 R7
      end else if (nxt_keyLow == KEY_LOW_PORT && nxt_keyHigh == KEY_HIGH_PORT) begin
         nxt_pinOut = portData; // R13 R14
         nxt_pinOe = 1'b1;
      end
   end

   always_ff @(posedge sys_clk) begin
      pinOut_ff <= nxt_pinOut;
      pinOe_ff <= nxt_pinOe;
      holdOut_ff <= (nxt_state == ST_ACTIVE) || (nxt_state == ST_DELAY);
      fetchOut_ff <= (nxt_state == ST_FETCH);
      vecOut_ff <= RESET_VECTOR_ADDR | {15'h0000, nxt_fetchCnt}; // R6
      portOut_ff <= (nxt_keyLow == KEY_LOW_PORT) && (nxt_keyHigh == KEY_HIGH_PORT);
   end

   assign hrdata = hrdata_ff;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign resetPinOut = pinOut_ff;
   assign resetPinOe = pinOe_ff;
   assign coreResetHold = holdOut_ff;
   assign vectorFetch = fetchOut_ff;
   assign vectorAddr = vecOut_ff;
   assign portMode = portOut_ff;

   ////////////////////////////////////////////////////////////////////////
   // Checks
   logic [6:0] delayRun_ff;
   always_ff @(posedge sys_clk) begin
      delayRun_ff <= (state_ff == ST_DELAY) ? delayRun_ff + 7'h01 : 7'h00;
   end

   a_delay_length: assert property ( // R4
      @(posedge sys_clk) disable iff (reset)
      (state_ff == ST_DELAY && nxt_state == ST_FETCH) |-> delayRun_ff == 7'(DELAY_CYCLES - 1))
      else $error("delay phase not 64 cycles");
   a_fetch_two: assert property ( // R5
      @(posedge sys_clk) disable iff (reset)
      ($rose(state_ff == ST_FETCH) && !anyReq ##1 !anyReq) |=> state_ff == ST_RUN)
      else $error("fetch phase not 2 cycles");
   a_fetch_vector: assert property ( // R6
      @(posedge sys_clk) disable iff (reset)
      $rose(vectorFetch) |-> vectorAddr == 16'hFFFE)
      else $error("wrong reset vector");
   a_pin_low_delay: assert property ( // R3
      @(posedge sys_clk) disable iff (reset)
      (state_ff == ST_DELAY) |-> resetPinOe && !resetPinOut)
      else $error("pin released during delay");
   a_wdg_width: assert property ( // R10
      @(posedge sys_clk) disable iff (reset)
      wdgUnderflow |=> (resetPinOe && !resetPinOut) [*8])
      else $error("watchdog pin pulse too short");
   a_lvd_holds: assert property ( // R9
      @(posedge sys_clk) disable iff (reset)
      lvdLow_ff |-> ##1 state_ff == ST_ACTIVE)
      else $error("low supply not holding reset");
   a_illegal_starts: assert property ( // R2
      @(posedge sys_clk) disable iff (reset)
      illegalOpcode |=> state_ff == ST_ACTIVE)
      else $error("illegal code did not reset");
   a_write_once: assert property ( // R11
      @(posedge sys_clk) disable iff (reset)
      (lowDone_ff && state_ff == ST_RUN && !anyReq) |=> $stable(keyLow_ff))
      else $error("low key rewritten");
   a_keys_cleared: assert property ( // R15
      @(posedge sys_clk) disable iff (reset)
      internalReq |=> keyLow_ff == 8'h00 && keyHigh_ff == 8'h00)
      else $error("keys not cleared by reset");
   a_restart_seq: assert property ( // R16
      @(posedge sys_clk) disable iff (reset)
      (state_ff == ST_FETCH && anyReq) |=> state_ff == ST_ACTIVE)
      else $error("no restart on new source");
   c_full_seq: cover property (@(posedge sys_clk) $fell(state_ff == ST_FETCH));
   c_port_mode: cover property (@(posedge sys_clk) $rose(portMode));
   c_ext_reset: cover property (@(posedge sys_clk) extReq && state_ff == ST_RUN);
endmodule
`default_nettype wire

// ---- tb/ext_pin_model.sv ----
// Board model around the shared reset pin: weak pull-up and an outside reset source.
// Assumes the bench raises extPull to imitate outside logic pulling the pin low.
`timescale 1ns/1ps
`default_nettype none
module ext_pin_model (
   input wire logic pinOut,   // Device drive value
   input wire logic pinOe,    // Device drive enable
   input wire logic portMode, // Device pin works push-pull
   input wire logic extPull,  // Outside circuit pulls low
   output logic pinLevel      // Resolved pin level
);
   // Port mode is push-pull, so the device decides the level there
   always_comb begin
      if (portMode && pinOe) begin
         pinLevel = pinOut;
      end else if ((pinOe && !pinOut) || extPull) begin
         pinLevel = 1'b0;
      end else begin
         pinLevel = 1'b1;
      end
   end
endmodule
`default_nettype wire

// ---- tb/tb_reset_sequence_manager.sv ----
// Self-checking bench of the reset sequence manager.
// Assumes ext_pin_model resolves the pin and the package gives all figures.
`timescale 1ns/1ps
`default_nettype none
module tb_reset_sequence_manager
   import rsm_pkg::*;
();
   typedef struct {int src; bit port; int minLow; int cause;} row_t;
   // Port data starts high, so port mode hides no reset pin time until the port test drives it low
   logic sys_clk = 1'b0, reset = 1'b1, hsel = 1'b0, hwrite = 1'b0, portData = 1'b1;
   logic lowSupply = 1'b0, wdgUnderflow = 1'b0, illegalOpcode = 1'b0, extPull = 1'b0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = 3'h2;
   logic hreadyout, hresp, resetPinOut, resetPinOe, coreResetHold, vectorFetch, portMode;
   logic pinLevel;
   logic [15:0] vectorAddr;
   int error_cnt = 0;
   int checks = 0;
   int lowRun = 0;
   // Sources: 0 pin, 1 supply, 2 watchdog, 3 illegal code
   row_t rows[4] = '{'{0, 1'b0, DELAY_CYCLES, CAUSE_EXT_BIT},
      '{1, 1'b1, DELAY_CYCLES, CAUSE_DROP_BIT},
      '{2, 1'b1, WDG_OUT_CYCLES + DELAY_CYCLES, CAUSE_WDG_BIT},
      '{3, 1'b1, DELAY_CYCLES, CAUSE_ILL_BIT}};

   always #(CLK_PERIOD_NS / 2) sys_clk = ~sys_clk;

   // Consecutive low pin cycles, sampled mid-cycle where the level has settled
   always @(negedge sys_clk) begin
      lowRun <= (pinLevel === 1'b0) ? lowRun + 1 : 0;
   end

   reset_sequence_manager reset_sequence_manager_inst (.sys_clk(sys_clk), .reset(reset),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .resetPinIn(pinLevel), .resetPinOut(resetPinOut),
      .resetPinOe(resetPinOe), .portData(portData), .lowSupply(lowSupply),
      .wdgUnderflow(wdgUnderflow), .illegalOpcode(illegalOpcode),
      .coreResetHold(coreResetHold), .vectorFetch(vectorFetch), .vectorAddr(vectorAddr),
      .portMode(portMode));
   ext_pin_model ext_pin_model_inst (.pinOut(resetPinOut), .pinOe(resetPinOe),
      .portMode(portMode), .extPull(extPull), .pinLevel(pinLevel));

   ////////////////////////////////////////////////////////////////////////////////
   // Closing report, shared by the main sequence and every bounded wait
   task automatic give_verdict();
      $display("Checks %0d, mismatches %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
      checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("Error at %0t: %s, seen %h expected %h", $time, msg, seen, exp);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask

   // One single word transfer; waits on hready, never on a fixed count
   task automatic ahb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
      int n;
      n = 0;
      @(posedge sys_clk);
      hsel <= 1'b1;
      htrans <= HTRANS_NONSEQ;
      hwrite <= wr;
      haddr <= {22'h0, idx, 2'b00};
      do begin
         @(posedge sys_clk);
         n++;
      end while (hreadyout !== 1'b1 && n < 50);
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= wd;
      do begin
         @(posedge sys_clk);
         n++;
      end while (hreadyout !== 1'b1 && n < 100);
      rd = hrdata;
      if (n >= 100) begin
         check(32'h0, 32'h1, "bus hang");
         give_verdict();
      end
   endtask

   task automatic readCheck(input logic [7:0] idx, input logic [31:0] exp, input string msg);
      ahb(1'b0, idx, 32'h0);
      check(rd, exp, msg);
   endtask

   // Waits for the fetch, then checks the low pin run before it and the fetch itself
   task automatic waitSeq(input int minLow);
      int n;
      n = 0;
      while (vectorFetch !== 1'b1 && n < 3000) begin
         tick(1);
         n++;
      end
      if (n >= 3000) begin
         check(32'h0, 32'h1, "sequence hang");
         give_verdict();
      end
      check(32'(lowRun >= minLow), 32'h1, "pin low too short");
      check(32'(vectorAddr), 32'(RESET_VECTOR_ADDR), "first fetch address");
      tick(1);
      check(32'({vectorFetch, vectorAddr}), 32'h1FFFF, "second fetch cycle");
      tick(1);
      check(32'({vectorFetch, coreResetHold, resetPinOe}), 32'h0, "sequence not over");
   endtask

   // Raises one source; pin and supply are held, the two pulses last one cycle
   task automatic fire(input int src);
      @(posedge sys_clk);
      case (src)
         0: extPull <= 1'b1;
         1: lowSupply <= 1'b1;
         2: wdgUnderflow <= 1'b1;
         default: illegalOpcode <= 1'b1;
      endcase
      repeat (src < 2 ? 20 : 1) @(posedge sys_clk);
      wdgUnderflow <= 1'b0;
      illegalOpcode <= 1'b0;
      #1;
      if (src < 2) check(32'(coreResetHold), 32'h1, "source ignored");
      if (src == 1) check(32'({resetPinOe, resetPinOut}), 32'h2, "pin released");
      @(posedge sys_clk);
      extPull <= 1'b0;
      lowSupply <= 1'b0;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (3) @(posedge sys_clk);
      reset <= 1'b0;
      waitSeq(DELAY_CYCLES);
      readCheck(KEY_LOW_IDX, 32'h0, "low key after reset");
      readCheck(KEY_HIGH_IDX, 32'h0, "high key after reset");
      check(32'({portMode, hresp}), 32'h0, "pin not in reset role");
      $display("Test reset done");
      // Table of sources; a key write first so each clear is visible
      foreach (rows[i]) begin
         ahb(1'b1, KEY_LOW_IDX, {24'h0, KEY_LOW_PORT});
         if (rows[i].port) begin
            ahb(1'b1, KEY_HIGH_IDX, {24'h0, KEY_HIGH_PORT});
            tick(2);
            check(32'(portMode), 32'h1, "port mode off");
         end
         fire(rows[i].src);
         waitSeq(rows[i].minLow);
         readCheck(KEY_LOW_IDX, 32'h0, "key survived reset");
         readCheck(CAUSE_IDX, 32'h1 << rows[i].cause, "reset cause");
         check(32'(portMode), 32'h0, "port mode survived");
         $display("Test source row %0d done", i);
      end
      // Write-once keys, port mode and its lock
      ahb(1'b1, KEY_LOW_IDX, 32'h55);
      ahb(1'b1, KEY_LOW_IDX, 32'h12);
      readCheck(KEY_LOW_IDX, 32'h55, "second low write taken");
      ahb(1'b1, KEY_HIGH_IDX, 32'hAA);
      ahb(1'b1, KEY_HIGH_IDX, 32'h00);
      readCheck(KEY_HIGH_IDX, 32'hAA, "second high write taken");
      readCheck(8'h50, 32'h0, "unmapped read");
      @(posedge sys_clk);
      portData <= 1'b1;
      tick(3);
      check(32'({portMode, resetPinOe, resetPinOut}), 32'h7, "port drive high");
      @(posedge sys_clk);
      portData <= 1'b0;
      extPull <= 1'b1;
      tick(20);
      check(32'({coreResetHold, resetPinOut}), 32'h0, "pin reset in port mode");
      @(posedge sys_clk);
      extPull <= 1'b0;
      $display("Test write once done");
      // A watchdog pulse in mid-delay restarts the sequence in full
      fire(3);
      tick(30);
      fire(2);
      waitSeq(WDG_OUT_CYCLES + DELAY_CYCLES);
      readCheck(CAUSE_IDX, 32'h1 << CAUSE_WDG_BIT, "restart cause");
      $display("Test restart done");
      // Low supply from reset onward counts as power-on
      @(posedge sys_clk);
      reset <= 1'b1;
      lowSupply <= 1'b1;
      repeat (3) @(posedge sys_clk);
      reset <= 1'b0;
      repeat (10) @(posedge sys_clk);
      lowSupply <= 1'b0;
      waitSeq(DELAY_CYCLES);
      readCheck(CAUSE_IDX, 32'h1 << CAUSE_POR_BIT, "power-on cause");
      $display("Test power-on done");
      give_verdict();
   end
endmodule
`default_nettype wire
